// file: hw/slave_defs.svh
// offsets, field positions, reset values and timing counts of the slave link
`ifndef SLAVE_DEFS_SVH
`define SLAVE_DEFS_SVH
// device registers on the link
`define OFS_PRESCALER 12'h400
`define OFS_IFC_WD 12'h410
`define OFS_NET_WD 12'h420
`define PRESCALER_RST 16'h09C2
`define IFC_WD_RST 16'h03E8
`define NET_WD_RST 16'h03E8
// timing
`define CLK_PERIOD_NS 100
`define WD_BASE_NS 40
`define WD_DEFAULT_MS 100
`define WD_HALF_STEP 18'((2 * `CLK_PERIOD_NS) / (`WD_BASE_NS / 2) / 2)
`define SAFE_OUT 8'h00
// controller registers on the software bus
`define AXI_OFS_ADDR 8'h00
`define AXI_OFS_DATA 8'h04
`define AXI_OFS_CMD 8'h08
`define AXI_OFS_STATUS 8'h0C
`define AXI_OFS_RDATA 8'h10
`define CMD_KIND_LSB 0
`define CMD_WRITE_BIT 2
`define ST_BUSY_BIT 0
`define ST_ERR_BIT 1
`define ST_STATE_LSB 4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: hw/slave_pkg.sv
// types shared by both ends of the slave link
package slave_pkg;
  typedef enum logic [3:0] {
    ST_INIT = 4'h1,
    ST_PREOP = 4'h2,
    ST_BOOT = 4'h3,
    ST_SAFEOP = 4'h4,
    ST_OP = 4'h8
  } slave_state_type;
  typedef enum logic [1:0] {
    MB_GENERIC = 2'h0,
    MB_PARAM = 2'h1,
    MB_FILE = 2'h2,
    MB_OTHER = 2'h3
  } mbx_proto_type;
  typedef enum logic [1:0] {
    REQ_STATE = 2'h0,
    REQ_REG = 2'h1,
    REQ_MBX = 2'h2,
    REQ_PD = 2'h3
  } req_kind_type;
endpackage

// file: hw/slave_link_if.sv
// link between the network master controller and the slave device
`timescale 1ns/1ps
interface slave_link_if;
  logic req;
  logic [1:0] kind;
  logic wr;
  logic [11:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic err;
  logic [15:0] rdata;
  modport device (input req, kind, wr, addr, wdata, output ack, err, rdata);
  modport master (output req, kind, wr, addr, wdata, input ack, err, rdata);
endinterface

// file: hw/slave_device.sv
// slave state machine, process image and the two communication watchdogs
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "slave_defs.svh"
// Notes on behaviour
// - power-up lands in init, no traffic
// - master sets mailbox channels in init
// - init to preop needs good mailbox setup
// - preop allows mailbox, blocks process data
// - master configures process data in preop
// - preop to safeop checks process, clock setup
// - inputs copied before safeop is acknowledged
// - safeop: traffic allowed, inputs cycle, outputs safe
// - master sends valid outputs before op
// - op drives master outputs onto pins
// - boot reachable only from init
// - boot accepts only file transfer mailbox
// - expired watchdog forces preset safe outputs
// - two independent watchdogs, 100 ms default
// - shared prescaler 400h, counts 410h, 420h
// - tick is prescaler plus two base periods
// - network watchdog restarts on process access
// - network watchdog expiry keeps slave state
// - interface watchdog fires on local silence
// - count zero disables the watchdog
// - master writes timing only when selected
// - counts accept values up to 65535
module slave_device import slave_pkg::*; (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // link to the network master
  slave_link_if.device LINK,
  // local process side
  input wire logic [7:0] INPUTS,
  input wire logic IFC_ACCESS,
  input wire logic MBX_CFG_OK,
  input wire logic PD_CFG_OK,
  input wire logic DC_CFG_OK,
  // process outputs and status
  output logic [7:0] OUTPUTS,
  output logic NET_WD_EXPIRED,
  output logic IFC_WD_EXPIRED,
  output logic [3:0] STATE
);

  slave_state_type state_ff;
  logic [15:0] presc_ff;
  logic [15:0] ifc_cnt_ff;
  logic [15:0] net_cnt_ff;
  logic [7:0] in_image_ff;
  logic [7:0] out_image_ff;
  logic out_valid_ff;
  logic ack_ff;
  logic err_ff;
  logic [15:0] rdata_ff;
  logic [17:0] acc_ff;
  logic tick_ff;
  logic [17:0] tick_lim;
  logic [17:0] acc_sum;
  logic [15:0] wd_ticks_ff [2];
  logic wd_exp_ff [2];
  logic [15:0] wd_limit [2];
  logic wd_kick [2];
  logic st_req;
  logic st_ok;
  logic mbx_req;
  logic mbx_ok;
  logic pd_req;
  logic pd_ok;
  logic reg_wr;
  logic [3:0] req_code;

  // transition table; any state may fall back to init, and safeop and op also to a lower state
  function automatic logic trans_ok(slave_state_type cur, logic [3:0] nxt,
                                    logic mbx_good, logic pd_good, logic out_good);
    case (nxt)
      ST_INIT: trans_ok = 1'b1;
      ST_PREOP: trans_ok = (cur == ST_INIT && mbx_good) || cur == ST_PREOP ||
                           cur == ST_SAFEOP || cur == ST_OP;
      ST_BOOT: trans_ok = cur == ST_INIT || cur == ST_BOOT;
      ST_SAFEOP: trans_ok = (cur == ST_PREOP && pd_good) || cur == ST_SAFEOP ||
                            cur == ST_OP;
      ST_OP: trans_ok = (cur == ST_SAFEOP && out_good) || cur == ST_OP;
      default: trans_ok = 1'b0;
    endcase
  endfunction

  // which mailbox protocols each state lets through
  function automatic logic mbx_allowed(slave_state_type cur, logic [1:0] proto);
    case (cur)
      ST_PREOP, ST_SAFEOP, ST_OP: mbx_allowed = 1'b1;
      ST_BOOT: mbx_allowed = proto == MB_FILE;
      default: mbx_allowed = 1'b0;
    endcase
  endfunction

  assign req_code = LINK.wdata[3:0];
  assign st_req = LINK.req && LINK.kind == REQ_STATE;
  assign mbx_req = LINK.req && LINK.kind == REQ_MBX;
  assign pd_req = LINK.req && LINK.kind == REQ_PD;
  assign reg_wr = LINK.req && LINK.kind == REQ_REG && LINK.wr;
  assign st_ok = trans_ok(state_ff, req_code, MBX_CFG_OK, PD_CFG_OK && DC_CFG_OK, out_valid_ff);
  assign mbx_ok = mbx_allowed(state_ff, LINK.wdata[1:0]);
  assign pd_ok = state_ff == ST_SAFEOP || state_ff == ST_OP;

  // slave state; watchdog expiry never moves it
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= ST_INIT;
    end else if (st_req && st_ok) begin
      state_ff <= slave_state_type'(req_code);
    end
  end

  // answer to every link request, one cycle after it
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end else begin
      ack_ff <= LINK.req;
      err_ff <= 1'b0;
      if (LINK.req) begin
        case (LINK.kind)
          REQ_STATE: begin
            err_ff <= !st_ok;
            rdata_ff <= {12'h000, st_ok ? req_code : state_ff};
          end
          REQ_REG: begin
            case (LINK.addr)
              `OFS_PRESCALER: rdata_ff <= presc_ff;
              `OFS_IFC_WD: rdata_ff <= ifc_cnt_ff;
              `OFS_NET_WD: rdata_ff <= net_cnt_ff;
              default: rdata_ff <= 16'h0000;
            endcase
          end
          REQ_MBX: err_ff <= !mbx_ok;
          REQ_PD: begin
            err_ff <= !pd_ok;
            rdata_ff <= {8'h00, in_image_ff};
          end
          default: err_ff <= 1'b1;
        endcase
      end
    end
  end

  // timing registers; full 16-bit range, nothing clamps them
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      presc_ff <= `PRESCALER_RST;
      ifc_cnt_ff <= `IFC_WD_RST;
      net_cnt_ff <= `NET_WD_RST;
    end else if (reg_wr) begin
      case (LINK.addr)
        `OFS_PRESCALER: presc_ff <= LINK.wdata;
        `OFS_IFC_WD: ifc_cnt_ff <= LINK.wdata;
        `OFS_NET_WD: net_cnt_ff <= LINK.wdata;
        default: ;
      endcase
    end
  end

  // input image: snapshot on entry to safeop, then refreshed every cycle
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      in_image_ff <= 8'h00;
    end else if (st_req && st_ok && req_code == ST_SAFEOP && state_ff == ST_PREOP) begin
      in_image_ff <= INPUTS;
    end else if (state_ff == ST_SAFEOP || state_ff == ST_OP) begin
      in_image_ff <= INPUTS;
    end
  end

  // output image from the master; validity lost on leaving safeop and op
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      out_image_ff <= 8'h00;
      out_valid_ff <= 1'b0;
    end else if (pd_req && pd_ok && LINK.wr) begin
      out_image_ff <= LINK.wdata[7:0];
      out_valid_ff <= 1'b1;
    end else if (!pd_ok) begin
      out_valid_ff <= 1'b0;
    end
  end

  // tick accumulator in half base periods, so 100 ns steps stay exact
  assign tick_lim = {1'b0, presc_ff, 1'b0} + 18'h00004;
  assign acc_sum = acc_ff + `WD_HALF_STEP;

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      acc_ff <= 18'h00000;
      tick_ff <= 1'b0;
    end else if (reg_wr && LINK.addr == `OFS_PRESCALER) begin
      acc_ff <= 18'h00000; // restart phase: a stale sum would tick every cycle
      tick_ff <= 1'b0;
    end else if (acc_sum >= tick_lim) begin
      acc_ff <= acc_sum - tick_lim;
      tick_ff <= 1'b1;
    end else begin
      acc_ff <= acc_sum;
      tick_ff <= 1'b0;
    end
  end

  // index 0 watches the network side, index 1 the local interface
  assign wd_kick[0] = pd_req && pd_ok;
  assign wd_kick[1] = IFC_ACCESS;
  assign wd_limit[0] = net_cnt_ff;
  assign wd_limit[1] = ifc_cnt_ff;

  // shared tick phase is not restarted by a kick: up to one tick of slack
  for (genvar g = 0; g < 2; g++) begin : g_wd
    always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
        wd_ticks_ff[g] <= 16'h0000;
        wd_exp_ff[g] <= 1'b0;
      end else if (wd_kick[g] || wd_limit[g] == 16'h0000) begin
        wd_ticks_ff[g] <= 16'h0000;
        wd_exp_ff[g] <= 1'b0;
      end else if (wd_ticks_ff[g] >= wd_limit[g]) begin
        wd_exp_ff[g] <= 1'b1;
      end else if (tick_ff) begin
        wd_ticks_ff[g] <= wd_ticks_ff[g] + 16'h0001;
      end
    end
  end

  // pins: master data only in op with both watchdogs quiet
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      OUTPUTS <= `SAFE_OUT;
      NET_WD_EXPIRED <= 1'b0;
      IFC_WD_EXPIRED <= 1'b0;
      STATE <= ST_INIT;
    end else begin
      if (state_ff == ST_OP && !wd_exp_ff[0] && !wd_exp_ff[1]) begin
        OUTPUTS <= out_image_ff;
      end else begin
        OUTPUTS <= `SAFE_OUT;
      end
      NET_WD_EXPIRED <= wd_exp_ff[0];
      IFC_WD_EXPIRED <= wd_exp_ff[1];
      STATE <= state_ff;
    end
  end

  assign LINK.ack = ack_ff;
  assign LINK.err = err_ff;
  assign LINK.rdata = rdata_ff;

endmodule // slave_device

// file: hw/slave_master.sv
// network master controller: AXI4-Lite registers in, link requests out
`timescale 1ns/1ps
`include "slave_defs.svh"
module slave_master import slave_pkg::*; (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // software register bus
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // link to the slave device
  slave_link_if.master LINK
);

  logic aw_have_ff;
  logic w_have_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic wr_fire;
  logic req_ff;
  logic [1:0] kind_ff;
  logic wr_ff;
  logic [11:0] addr_ff;
  logic [15:0] data_ff;
  logic busy_ff;
  logic err_ff;
  logic [3:0] state_ff;
  logic [15:0] rdata_ff;

  function automatic logic mapped(logic [7:0] a);
    mapped = a == `AXI_OFS_ADDR || a == `AXI_OFS_DATA || a == `AXI_OFS_CMD ||
             a == `AXI_OFS_STATUS || a == `AXI_OFS_RDATA;
  endfunction

  assign wr_fire = aw_have_ff && w_have_ff && !S_AXI_BVALID;

  // write channels taken in either order, answered after both
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_ff <= 1'b1;
        awaddr_ff <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_ff <= 1'b1;
        wdata_ff <= S_AXI_WDATA;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= mapped(awaddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // read channel, one outstanding
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= mapped(S_AXI_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
      case (S_AXI_ARADDR)
        `AXI_OFS_ADDR: S_AXI_RDATA <= {20'h00000, addr_ff};
        `AXI_OFS_DATA: S_AXI_RDATA <= {16'h0000, data_ff};
        `AXI_OFS_STATUS: S_AXI_RDATA <= {24'h000000, state_ff, 2'h0, err_ff, busy_ff};
        `AXI_OFS_RDATA: S_AXI_RDATA <= {16'h0000, rdata_ff};
        default: S_AXI_RDATA <= 32'h00000000;
      endcase
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // staged address and data; device timing is written only on command
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      addr_ff <= 12'h000;
      data_ff <= 16'h0000;
    end else if (wr_fire && S_AXI_WSTRB[0]) begin
      if (awaddr_ff == `AXI_OFS_ADDR) begin
        addr_ff <= {S_AXI_WSTRB[1] ? wdata_ff[11:8] : addr_ff[11:8], wdata_ff[7:0]};
      end
      if (awaddr_ff == `AXI_OFS_DATA) begin
        data_ff <= {S_AXI_WSTRB[1] ? wdata_ff[15:8] : data_ff[15:8], wdata_ff[7:0]};
      end
    end
  end

  // one request at a time; a command while busy is dropped
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      req_ff <= 1'b0;
      kind_ff <= REQ_STATE;
      wr_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      req_ff <= 1'b0;
      if (wr_fire && awaddr_ff == `AXI_OFS_CMD && S_AXI_WSTRB[0] && !busy_ff) begin
        req_ff <= 1'b1;
        kind_ff <= wdata_ff[`CMD_KIND_LSB +: 2];
        wr_ff <= wdata_ff[`CMD_WRITE_BIT];
        busy_ff <= 1'b1;
      end else if (LINK.ack) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // answer capture; state requests echo the slave's resulting state
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      err_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      state_ff <= ST_INIT;
    end else if (LINK.ack && busy_ff) begin
      err_ff <= LINK.err;
      rdata_ff <= LINK.rdata;
      if (kind_ff == REQ_STATE) begin
        state_ff <= LINK.rdata[3:0];
      end
    end
  end

  assign LINK.req = req_ff;
  assign LINK.kind = kind_ff;
  assign LINK.wr = wr_ff;
  assign LINK.addr = addr_ff;
  assign LINK.wdata = data_ff;

endmodule // slave_master

// file: sim/slave_link_props.sv
// checker of the slave link: answer timing and refusal rules
`timescale 1ns/1ps
module slave_link_props import slave_pkg::*; (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // link signals
  input wire logic req,
  input wire logic [1:0] kind,
  input wire logic wr,
  input wire logic [11:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic err,
  input wire logic [15:0] rdata
);
  logic [3:0] cur_state_ff;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  // state as answered on the link; only state requests may move it
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      cur_state_ff <= ST_INIT;
    end else if (ack && kind == REQ_STATE) begin
      cur_state_ff <= rdata[3:0];
    end
  end
  ack_after_req_a: assert property (req |=> ack ##1 !ack)
    else $error("link answer missing or long");
  init_mbx_shut_a: assert property (req && kind == REQ_MBX &&
    cur_state_ff == ST_INIT |=> ack && err)
    else $error("mailbox taken in init");
  open_mbx_a: assert property (req && kind == REQ_MBX &&
    cur_state_ff inside {ST_PREOP, ST_SAFEOP, ST_OP} |=> ack && !err)
    else $error("mailbox refused while open");
  closed_pd_a: assert property (req && kind == REQ_PD &&
    cur_state_ff inside {ST_INIT, ST_PREOP, ST_BOOT} |=> err)
    else $error("process data taken while closed");
  open_pd_a: assert property (req && kind == REQ_PD &&
    cur_state_ff inside {ST_SAFEOP, ST_OP} |=> ack && !err)
    else $error("process data refused while open");
  boot_file_a: assert property (req && kind == REQ_MBX && cur_state_ff == ST_BOOT
    |=> err == (wdata[1:0] != MB_FILE))
    else $error("boot mailbox filter wrong");
  boot_entry_a: assert property (req && kind == REQ_STATE && wdata[3:0] == ST_BOOT &&
    !(cur_state_ff inside {ST_INIT, ST_BOOT}) |=> err)
    else $error("boot reached from wrong state");
  refuse_keeps_a: assert property (ack && err && kind == REQ_STATE
    |-> rdata[3:0] == cur_state_ff)
    else $error("refused transition moved state");
  accept_goes_a: assert property (ack && !err && kind == REQ_STATE
    |-> rdata[3:0] == wdata[3:0])
    else $error("accepted transition went elsewhere");
  cover property (ack && !err && kind == REQ_STATE && rdata[3:0] == ST_OP);
  cover property (req && kind == REQ_PD && wr && cur_state_ff == ST_OP);
  cover property (ack && !err && kind == REQ_MBX && cur_state_ff == ST_BOOT);
endmodule // slave_link_props

// file: sim/tb_slave_state_and_watchdog.sv
// bench: both link ends, driven over the software bus and local pins
`timescale 1ns/1ps
module tb_slave_state_and_watchdog import slave_pkg::*;;
  logic clock = 1'b0, reset_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, ifc_access = 1'b0, mbx_ok = 1'b0;
  logic pd_ok = 1'b0, dc_ok = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, inputs_v = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, net_exp, ifc_exp, res_err;
  logic [1:0] bresp, rresp;
  logic [31:0] rdat;
  logic [7:0] outputs_v;
  logic [3:0] state;
  logic [15:0] res_data;
  int fails = 0, checks = 0;
  always #50 clock = ~clock;
  slave_link_if link_if();
  slave_master i_slave_master(.CLOCK(clock), .RESET_N(reset_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdat),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .LINK(link_if.master));
  slave_device i_slave_device(.CLOCK(clock), .RESET_N(reset_n), .LINK(link_if.device),
    .INPUTS(inputs_v), .IFC_ACCESS(ifc_access), .MBX_CFG_OK(mbx_ok), .PD_CFG_OK(pd_ok),
    .DC_CFG_OK(dc_ok), .OUTPUTS(outputs_v), .NET_WD_EXPIRED(net_exp),
    .IFC_WD_EXPIRED(ifc_exp), .STATE(state));
  slave_link_props i_slave_link_props(.CLOCK(clock), .RESET_N(reset_n),
    .req(link_if.req), .kind(link_if.kind), .wr(link_if.wr), .addr(link_if.addr),
    .wdata(link_if.wdata), .ack(link_if.ack), .err(link_if.err), .rdata(link_if.rdata));

  task automatic end_sim();
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t ns: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    awaddr <= a;
    wdat <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdat;
    r = rresp;
    rready <= 1'b0;
  endtask
  // one link request; busy is polled, the limit only guards a stuck master
  task automatic link(input logic [1:0] k, input logic w, input logic [11:0] a,
                      input logic [15:0] d);
    logic [31:0] v;
    logic [1:0] r;
    int n;
    axi_wr(8'h00, {20'h0, a}, r);
    axi_wr(8'h04, {16'h0, d}, r);
    axi_wr(8'h08, {29'h0, w, k}, r);
    n = 0;
    do begin
      axi_rd(8'h0C, v, r);
      n++;
    end while (v[0] !== 1'b0 && n < 20);
    if (v[0] !== 1'b0) begin
      fails++;
      $display("unexpected at %0t ns: link answer never came", $time);
    end
    res_err = v[1];
    axi_rd(8'h10, v, r);
    res_data = v[15:0];
  endtask
  task automatic st(input logic [3:0] code, input logic e, input logic [3:0] want);
    link(REQ_STATE, 1'b0, 12'h000, {12'h000, code});
    cmp({3'h0, res_err, res_data[3:0], 4'h0, state}, {3'h0, e, want, 4'h0, want});
  endtask

  task automatic t_regs();
    logic [31:0] v;
    logic [1:0] r;
    cmp({3'h0, net_exp, state, outputs_v}, 16'h0100);
    link(REQ_REG, 1'b0, 12'h400, 16'h0000);
    cmp(res_data, 16'h09C2);
    link(REQ_REG, 1'b0, 12'h410, 16'h0000);
    cmp(res_data, 16'h03E8);
    link(REQ_REG, 1'b0, 12'h420, 16'h0000);
    cmp(res_data, 16'h03E8);
    link(REQ_REG, 1'b1, 12'h410, 16'hFFFF);
    link(REQ_REG, 1'b0, 12'h410, 16'h0000);
    cmp(res_data, 16'hFFFF);
    axi_wr(8'hFC, 32'h1, r);
    cmp({14'h0, r}, 16'h0002);
    axi_rd(8'hFC, v, r);
    cmp({14'h0, r}, 16'h0002);
  endtask
  task automatic t_bringup();
    link(REQ_MBX, 1'b0, 12'h000, 16'h0001);
    cmp({15'h0, res_err}, 16'h0001);
    st(ST_PREOP, 1'b1, ST_INIT);
    mbx_ok <= 1'b1;
    st(ST_PREOP, 1'b0, ST_PREOP);
    link(REQ_MBX, 1'b0, 12'h000, 16'h0001);
    cmp({15'h0, res_err}, 16'h0000);
    link(REQ_PD, 1'b1, 12'h000, 16'h0033);
    cmp({15'h0, res_err}, 16'h0001);
    st(ST_BOOT, 1'b1, ST_PREOP);
    st(ST_SAFEOP, 1'b1, ST_PREOP);
    pd_ok <= 1'b1;
    dc_ok <= 1'b0;
    st(ST_SAFEOP, 1'b1, ST_PREOP);
    dc_ok <= 1'b1;
    inputs_v <= 8'h5A;
    st(ST_SAFEOP, 1'b0, ST_SAFEOP);
    link(REQ_PD, 1'b0, 12'h000, 16'h0000);
    cmp(res_data, 16'h005A);
    st(ST_OP, 1'b1, ST_SAFEOP);
    link(REQ_PD, 1'b1, 12'h000, 16'h00C3);
    cmp({7'h0, res_err, outputs_v}, 16'h0000);
    st(ST_OP, 1'b0, ST_OP);
    cmp({8'h00, outputs_v}, 16'h00C3);
  endtask
  // prescaler 3 gives a tick every 2 cycles, so count 40 is 80 cycles
  // local access held high keeps the interface watchdog quiet until released
  task automatic t_wdog();
    ifc_access <= 1'b1;
    link(REQ_REG, 1'b1, 12'h400, 16'h0003);
    link(REQ_REG, 1'b1, 12'h420, 16'h0028);
    link(REQ_REG, 1'b1, 12'h410, 16'h0028);
    link(REQ_PD, 1'b1, 12'h000, 16'h00C3);
    tick(50);
    cmp({3'h0, net_exp, state, outputs_v}, 16'h08C3);
    tick(50);
    cmp({3'h0, net_exp, state, outputs_v}, 16'h1800);
    link(REQ_PD, 1'b1, 12'h000, 16'h003C);
    cmp({3'h0, net_exp, state, outputs_v}, 16'h083C);
    ifc_access <= 1'b0;
    tick(100);
    link(REQ_PD, 1'b1, 12'h000, 16'h003C);
    cmp({6'h0, net_exp, ifc_exp, outputs_v}, 16'h0100);
    link(REQ_REG, 1'b1, 12'h420, 16'h0000);
    ifc_access <= 1'b1;
    tick(1);
    ifc_access <= 1'b0;
    link(REQ_REG, 1'b1, 12'h410, 16'h0000);
    cmp({6'h0, net_exp, ifc_exp, outputs_v}, 16'h003C);
    tick(150);
    cmp({6'h0, net_exp, ifc_exp, outputs_v}, 16'h003C);
  endtask
  task automatic t_boot();
    st(ST_INIT, 1'b0, ST_INIT);
    st(ST_BOOT, 1'b0, ST_BOOT);
    for (int p = 0; p < 4; p++) begin
      link(REQ_MBX, 1'b0, 12'h000, 16'(p));
      cmp({15'h0, res_err}, {15'h0, p != 2});
    end
    link(REQ_PD, 1'b0, 12'h000, 16'h0000);
    cmp({15'h0, res_err}, 16'h0001);
    st(ST_PREOP, 1'b1, ST_BOOT);
    st(ST_INIT, 1'b0, ST_INIT);
  endtask

  initial begin
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    t_regs();
    t_bringup();
    t_wdog();
    t_boot();
    end_sim();
  end
  // about 35 requests of some 20 cycles plus waits; far below this span
  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    $display("unexpected at %0t ns: run timed out", $time);
    end_sim();
  end
endmodule // tb_slave_state_and_watchdog
